// [design/ccp_unit_defs.svh]
// constants for the capture/compare/pwm unit: offsets, fields, reset values
`ifndef CCP_UNIT_DEFS_SVH
`define CCP_UNIT_DEFS_SVH
`define ADDR_CONTROL 2'h0
`define ADDR_MATCH_LOW 2'h1
`define ADDR_MATCH_HIGH 2'h2
`define ADDR_STATUS 2'h3
`define CTL_ENABLE_BIT 7
`define CTL_OUT_BIT 5
`define CTL_FMT_BIT 4
`define STS_FLAG_BIT 0
`define STS_ENABLE_BIT 1
`define STS_SELECT_BIT 2
`define CONTROL_RESET 8'h00
`define PRESCALE_ONE 2'h0
`endif

// [design/ccp_unit_pkg.sv]
// types for the capture/compare/pwm unit
package ccp_unit_pkg;
   typedef enum logic [3:0] {
      MODE_OFF = 4'b0000,
      MODE_TOGGLE_CLR = 4'b0001,
      MODE_TOGGLE = 4'b0010,
      MODE_SET = 4'b1000,
      MODE_CLEAR = 4'b1001,
      MODE_PULSE = 4'b1010,
      MODE_PULSE_CLR = 4'b1011,
      MODE_PWM = 4'b1111
   } mode_t;
endpackage

// [design/capture_compare_pwm_unit.sv]
// one compare/pwm channel with register port, sleep handling and conversion trigger
`include "ccp_unit_defs.svh"
module capture_compare_pwm_unit #(
   parameter int TIMER_WIDTH = 16,
   parameter int PERIOD_WIDTH = 8
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // register port
   input wire logic [1:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   output logic [7:0] reg_rdata_out,
   // sixteen-bit timer (outside) and its sleep behaviour
   input wire logic [15:0] sixteen_bit_timer_in,
   input wire logic timer_tick_in,
   input wire logic timer_external_clock_in,
   output logic timer_tick_enable_out,
   output logic timer_reset_out,
   // period timer settings
   input wire logic [7:0] period_limit_value_in,
   input wire logic [1:0] period_timer_prescale_in,
   input wire logic period_timer_run_in,
   // power state
   input wire logic sleep_in,
   output logic wake_out,
   // outputs
   output logic unit_output_pin_out,
   output logic adc_trigger_out,
   output logic period_timer_flag_out,
   output logic [7:0] period_timer_count_out
);
   import ccp_unit_pkg::*;

   // refuse widths that the fixed compare and period paths cannot serve
   if (TIMER_WIDTH != 16 || PERIOD_WIDTH != 8) begin : g_width_check
      $error("unit supports only 16-bit compare and 8-bit period timers");
   end

   // write strobe aimed at one register index; used by two processes
   function automatic logic write_to(input logic strobe, input logic [1:0] addr,
         input logic [1:0] index);
      return strobe && (addr == index);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0] unit_control_reg;
   logic [7:0] match_value_low;
   logic [7:0] match_value_high;
   logic match_event_flag;
   logic match_event_enable;
   logic adc_select;
   logic out_latch;
   logic [9:0] duty_buffer;
   logic [7:0] count;
   logic [3:0] pre_cnt;
   logic [1:0] phase;
   logic reset_pending;
   logic match_q;
   logic match_edge;

   mode_t mode;
   logic enabled;
   logic fmt;
   logic is_pwm;
   logic is_compare;
   logic [15:0] match_pair;
   logic [9:0] duty_value;
   logic compare_hit;
   logic compare_run;
   logic pwm_run;
   logic base_step;
   logic period_end;
   logic [9:0] time_base;
   logic [3:0] pre_limit;

   assign mode = mode_t'(unit_control_reg[3:0]);
   assign enabled = unit_control_reg[`CTL_ENABLE_BIT];
   assign fmt = unit_control_reg[`CTL_FMT_BIT];
   assign is_pwm = enabled && (mode == MODE_PWM);
   assign is_compare = enabled && unit_control_reg[3] == 1'b1 && !is_pwm
      || enabled && (mode == MODE_TOGGLE || mode == MODE_TOGGLE_CLR);
   // the pair is both compare value and pwm duty, so a mode change keeps it
   assign match_pair = {match_value_high, match_value_low};

   // duty value from the pair, right aligned in low bits or left aligned
   assign duty_value = fmt ? match_pair[15:6] : match_pair[9:0];

   ////////////////////////////////////////////////////////////////////////////
   // sleep gating of timers
   // instruction-clocked timer freezes in sleep; external source keeps going
   assign timer_tick_enable_out = !sleep_in || timer_external_clock_in;
   assign compare_run = timer_tick_enable_out;
   // pwm counters just stop, nothing is cleared, so wake resumes in place
   assign pwm_run = period_timer_run_in && !sleep_in;

   ////////////////////////////////////////////////////////////////////////////
   // compare path
   assign compare_hit = is_compare && compare_run
      && (sixteen_bit_timer_in == match_pair);
   // a held match acts once: only its first cycle counts as an event
   assign match_edge = compare_hit && !match_q;

   // match edge detect so a held match counts once
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         match_q <= 1'b0;
      end else begin
         match_q <= compare_hit;
      end
   end

   // timer reset follows the trigger edge and is dropped if the match vanished
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         reset_pending <= 1'b0;
      end else begin
         reset_pending <= match_edge
            && (mode == MODE_TOGGLE_CLR || mode == MODE_PULSE_CLR);
      end
   end
   assign timer_reset_out = reset_pending && compare_hit;

   // conversion trigger on the match edge
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         adc_trigger_out <= 1'b0;
      end else begin
         adc_trigger_out <= match_edge && adc_select;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pwm time base: prescaler ticks each system clock; low bits are phase
   always_comb begin
      unique case (period_timer_prescale_in)
         2'h0: pre_limit = 4'h0;
         2'h1: pre_limit = 4'h3;
         2'h2: pre_limit = 4'hF;
         2'h3: pre_limit = 4'hF; // spare code runs as 1:16
      endcase
   end
   // postscaler is deliberately absent from this path; the >= lets a count left
   // above a newly lowered limit step at once instead of wrapping through 15
   assign base_step = pwm_run && (pre_cnt >= pre_limit);
   assign time_base = {count, phase};
   // the last phase of the limit count ends the period: (limit+1)*4 steps
   assign period_end = base_step && phase == 2'h3
      && count == period_limit_value_in;

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         pre_cnt <= 4'h0;
      end else if (pwm_run) begin
         pre_cnt <= base_step ? 4'h0 : pre_cnt + 4'h1;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         phase <= 2'h0;
         count <= 8'h00;
      end else if (base_step) begin
         phase <= phase + 2'h1;
         if (phase == 2'h3) begin
            count <= period_end ? 8'h00 : count + 8'h01;
         end
      end
   end
   assign period_timer_count_out = count;

   // duty buffer loaded only at the period boundary
   // so a duty write in mid-period never cuts the pulse being produced
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         duty_buffer <= 10'h000;
      end else if (period_end) begin
         duty_buffer <= duty_value;
      end
   end

   // sticky until the period timer is stopped, so software can poll it
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         period_timer_flag_out <= 1'b0;
      end else if (period_end) begin
         period_timer_flag_out <= 1'b1;
      end else if (!period_timer_run_in) begin
         period_timer_flag_out <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output latch; a zero control write beats every mode action in that cycle
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         out_latch <= 1'b0;
      end else if (write_to(reg_write_in, reg_addr_in, `ADDR_CONTROL)
            && reg_wdata_in == `CONTROL_RESET) begin
         out_latch <= 1'b0;
      end else if (is_pwm) begin
         if (period_end) begin
            out_latch <= (duty_value != 10'h000);
         // clear on the step into the duty value, so high lasts exactly duty steps
         end else if (base_step && (time_base + 10'h1) == duty_buffer) begin
            out_latch <= 1'b0;
         end
      end else if (match_edge) begin
         unique case (mode)
            // a prescaled timer holds a match for several clocks; the edge detect toggles once at any prescale
            MODE_TOGGLE, MODE_TOGGLE_CLR: out_latch <= !out_latch;
            MODE_SET: out_latch <= 1'b1;
            MODE_CLEAR: out_latch <= 1'b0;
            // pulse modes raise the flag and trigger but leave the latch alone
            default: out_latch <= out_latch;
         endcase
      end
   end
   assign unit_output_pin_out = out_latch;

   ////////////////////////////////////////////////////////////////////////////
   // event flag: hardware set wins over software clear
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         match_event_flag <= 1'b0;
      end else if (match_edge) begin
         match_event_flag <= 1'b1;
      end else if (write_to(reg_write_in, reg_addr_in, `ADDR_STATUS)
            && !reg_wdata_in[`STS_FLAG_BIT]) begin
         match_event_flag <= 1'b0;
      end
   end
   // awake, the flag alone informs software; only in sleep does it wake
   assign wake_out = sleep_in && match_event_flag && match_event_enable;

   ////////////////////////////////////////////////////////////////////////////
   // register writes
   // status bit 0 (the flag) is handled by the flag process, not here
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         unit_control_reg <= `CONTROL_RESET;
         match_value_low <= 8'h00;
         match_value_high <= 8'h00;
         match_event_enable <= 1'b0;
         adc_select <= 1'b0;
      end else if (reg_write_in) begin
         unique case (reg_addr_in)
            `ADDR_CONTROL: unit_control_reg <= reg_wdata_in;
            `ADDR_MATCH_LOW: match_value_low <= reg_wdata_in;
            `ADDR_MATCH_HIGH: match_value_high <= reg_wdata_in;
            `ADDR_STATUS: begin
               match_event_enable <= reg_wdata_in[`STS_ENABLE_BIT];
               adc_select <= reg_wdata_in[`STS_SELECT_BIT];
            end
         endcase
      end
   end

   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_read_in) begin
         unique case (reg_addr_in)
            `ADDR_CONTROL: reg_rdata_out <= {unit_control_reg[7], 1'b0, out_latch,
               unit_control_reg[4:0]};
            `ADDR_MATCH_LOW: reg_rdata_out <= match_value_low;
            `ADDR_MATCH_HIGH: reg_rdata_out <= match_value_high;
            `ADDR_STATUS: reg_rdata_out <= {5'h00, adc_select, match_event_enable,
               match_event_flag};
         endcase
      end else begin
         reg_rdata_out <= 8'h00;
      end
   end
endmodule // capture_compare_pwm_unit

// [bench/ccp_unit_props.sv]
// concurrent checks on the ports of the compare/pwm unit
module ccp_unit_props (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic [1:0] period_timer_prescale_in,
   input wire logic [7:0] period_limit_value_in,
   input wire logic period_timer_run_in,
   input wire logic sleep_in,
   input wire logic timer_external_clock_in,
   input wire logic timer_tick_enable_out,
   input wire logic wake_out,
   input wire logic adc_trigger_out,
   input wire logic unit_output_pin_out,
   input wire logic [7:0] period_timer_count_out
);
   default clocking @(posedge sys_clk_in);
   endclocking
   default disable iff (reset_in);
   wake_in_sleep_a: assert property (wake_out |-> sleep_in)
      else $error("wake outside sleep");
   tick_held_a: assert property (sleep_in && !timer_external_clock_in |->
      !timer_tick_enable_out)
      else $error("timer ticks in sleep");
   tick_external_a: assert property (sleep_in && timer_external_clock_in |->
      timer_tick_enable_out)
      else $error("external timer stopped");
   adc_single_a: assert property (adc_trigger_out |=> !adc_trigger_out)
      else $error("trigger longer than one cycle");
   sleep_freeze_a: assert property (sleep_in && $past(sleep_in) |->
      $stable(period_timer_count_out) && $stable(unit_output_pin_out))
      else $error("pwm moved in sleep");
   count_limit_a: assert property (period_timer_run_in |->
      period_timer_count_out <= period_limit_value_in)
      else $error("count above limit");
   count_wrap_a: assert property ($changed(period_timer_count_out) |->
      period_timer_count_out == 8'($past(period_timer_count_out) + 1) ||
      period_timer_count_out == 8'h00)
      else $error("count jumped");
   // at 1:1 the two phase bits make four cycles per count
   phase_step_a: assert property (period_timer_run_in &&
      period_timer_prescale_in == 2'h0 && $changed(period_timer_count_out) |=>
      ($stable(period_timer_count_out) || !period_timer_run_in)[*3])
      else $error("count stepped early");
endmodule // ccp_unit_props
bind capture_compare_pwm_unit ccp_unit_props i_ccp_unit_props (.sys_clk_in, .reset_in,
   .period_timer_prescale_in, .period_limit_value_in, .period_timer_run_in, .sleep_in,
   .timer_external_clock_in, .timer_tick_enable_out, .wake_out, .adc_trigger_out,
   .unit_output_pin_out, .period_timer_count_out);

// [bench/pin_load.sv]
// load on the unit's output pin: counts high cycles and rising edges
module pin_load (
   // clock and window clear
   input wire logic clk_in,
   input wire logic clear_in,
   // observed pin
   input wire logic pin_in,
   // measurements
   output int high_out,
   output int rises_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last = 1'b0;
   // a window of whole periods makes the counts independent of phase
   always @(posedge clk_in) begin
      last <= pin_in;
      high_out <= clear_in ? 0 : high_out + int'(pin_in === 1'b1);
      rises_out <= clear_in ? 0 : rises_out + int'(pin_in === 1'b1 && last === 1'b0);
   end
endmodule // pin_load

// [bench/tb.sv]
// self-checking bench for the compare/pwm unit
`include "ccp_unit_defs.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ccp_unit_pkg::*;
   logic clk = 0, rst = 1, wr = 0, rd = 0, tick = 0, ext = 0, run = 0, slp = 0, clr = 0;
   logic [1:0] addr = 0, ps = 0;
   logic [7:0] wd = 0, rdat, cnt, lim = 8'h07;
   logic [15:0] tmr = 16'h0000;
   logic wake, pin, adc, flag, tren, trst;
   int hi, rises, adc_n = 0, rst_n = 0, err_count = 0, n_tests = 0, cyc = 0;
   int seed = 32'he72d22d1;
   mode_t md[5] = '{MODE_SET, MODE_CLEAR, MODE_TOGGLE, MODE_TOGGLE, MODE_TOGGLE_CLR};
   logic [1:0] pv[4] = '{2'h0, 2'h1, 2'h2, 2'h0};
   int dv[4] = '{13, 0, 5, 31};
   logic fm[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
   capture_compare_pwm_unit i_capture_compare_pwm_unit (.sys_clk_in(clk), .reset_in(rst),
      .reg_addr_in(addr), .reg_wdata_in(wd), .reg_write_in(wr), .reg_read_in(rd),
      .reg_rdata_out(rdat), .sixteen_bit_timer_in(tmr), .timer_tick_in(tick),
      .timer_external_clock_in(ext), .timer_tick_enable_out(tren), .timer_reset_out(trst),
      .period_limit_value_in(lim), .period_timer_prescale_in(ps), .period_timer_run_in(run),
      .sleep_in(slp), .wake_out(wake), .unit_output_pin_out(pin), .adc_trigger_out(adc),
      .period_timer_flag_out(flag), .period_timer_count_out(cnt));
   pin_load i_pin_load (.clk_in(clk), .clear_in(clr), .pin_in(pin), .high_out(hi),
      .rises_out(rises));
   initial forever #5 clk = ~clk;
   ////////////////////////////////////////////////////////////
   // pulse counters and the hang limit
   always @(posedge clk) begin
      cyc <= cyc + 1;
      tick <= 1'($random(seed));
      adc_n <= adc_n + int'(adc === 1'b1);
      rst_n <= rst_n + int'(trst === 1'b1);
      if (cyc == 20000) begin
         err_count++;
         test_done;
      end
   end
   task automatic wrt(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
   endtask
   task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", s, e, g);
      end
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rchk(input string s, input logic [1:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      #1 chk(s, e, rdat);
   endtask
   // timer moves only on clock edges, like a synchronised counter
   task automatic hit(input logic [15:0] v, input int n);
      @(posedge clk);
      tmr <= v;
      repeat (n) @(posedge clk);
      tmr <= ~v;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      logic [15:0] m;
      logic [15:0] d;
      int e;
      int k;
      int j;
      repeat (12) @(posedge clk);
      rst <= 0;
      m = 16'($random(seed));
      wrt(`ADDR_MATCH_LOW, m[7:0]);
      wrt(`ADDR_MATCH_HIGH, m[15:8]);
      rchk("match low", `ADDR_MATCH_LOW, m[7:0]);
      rchk("match high", `ADDR_MATCH_HIGH, m[15:8]);
      rchk("control", `ADDR_CONTROL, `CONTROL_RESET);
      wrt(`ADDR_STATUS, 8'h06);
      rchk("status", `ADDR_STATUS, 8'h06);
      $display("test registers done");
      // a held match acts once: hold grows with the index
      e = 0;
      foreach (md[i]) begin
         wrt(`ADDR_CONTROL, {4'h8, md[i]});
         e = (md[i] == MODE_SET) ? 1 : (md[i] == MODE_CLEAR) ? 0 : 1 - e;
         hit(m, 1 + i);
         chk("pin", 16'(e), 16'(pin));
         chk("adc", 16'(i + 1), 16'(adc_n));
         rchk("flag", `ADDR_STATUS, 8'h07);
         wrt(`ADDR_STATUS, 8'h06);
      end
      chk("timer reset", 16'h0001, 16'(rst_n));
      wrt(`ADDR_CONTROL, 8'h00);
      #1 chk("latch", 16'h0000, 16'(pin));
      wrt(`ADDR_CONTROL, {4'h8, MODE_TOGGLE_CLR});
      @(posedge clk);
      tmr <= m;
      addr <= `ADDR_MATCH_LOW;
      wd <= ~m[7:0];
      wr <= 1;
      @(posedge clk);
      wr <= 0;
      repeat (4) @(posedge clk);
      #1 chk("timer reset", 16'h0001, 16'(rst_n));
      chk("adc", 16'h0006, 16'(adc_n));
      $display("test compare done");
      @(posedge clk);
      tmr <= ~m;
      slp <= 1;
      ext <= 1;
      @(posedge clk);
      #1 chk("wake", 16'h0001, 16'(wake));
      chk("tick", 16'h0001, 16'(tren));
      @(posedge clk);
      ext <= 0;
      #1 chk("tick", 16'h0000, 16'(tren));
      wrt(`ADDR_STATUS, 8'h06);
      #1 chk("wake", 16'h0000, 16'(wake));
      slp <= 0;
      $display("test sleep done");
      foreach (pv[i]) begin
         k = pv[i] == 2'h0 ? 1 : pv[i] == 2'h1 ? 4 : 16;
         d = fm[i] ? 16'(dv[i] << 6) : 16'(dv[i]);
         run <= 0;
         wrt(`ADDR_MATCH_LOW, d[7:0]);
         wrt(`ADDR_MATCH_HIGH, d[15:8]);
         wrt(`ADDR_CONTROL, {3'h4, fm[i], MODE_PWM});
         ps <= pv[i];
         run <= 1;
         // look just after each edge so the flag is seen once it is settled
         for (j = 0; j < 40 * k && flag !== 1'b1; j++) begin
            @(posedge clk);
            #1;
         end
         chk("period flag", 16'h0001, 16'(flag));
         if (i == 2) begin
            slp <= 1;
            repeat (20) @(posedge clk);
            slp <= 0;
         end
         repeat (64 * k) @(posedge clk);
         clr <= 1;
         @(posedge clk);
         clr <= 0;
         repeat (96 * k) @(posedge clk);
         #1 chk("high", 16'(3 * dv[i] * k), 16'(hi));
         chk("rises", dv[i] != 0 ? 16'h0003 : 16'h0000, 16'(rises));
      end
      $display("test pwm done");
      test_done;
   end
endmodule // tb
